//--- include/exp_chan_pkg.sv
// Purpose: shared constants and types for the expansion channel
// Assumes: 20 MHz system clock on both ends
// Notes:   address window, timing counts and cycle states
`default_nettype none
package exp_chan_pkg;
    localparam int          ADDR_W       = 16;
    localparam int          DATA_W       = 16;
    localparam int          IRQ_N        = 8;
    localparam logic [15:0] WIN_BASE     = 16'h4000;
    localparam logic [15:0] WIN_LAST     = 16'h7fff;
    localparam logic [19:0] WIN_BASE_20  = 20'h04000;
    localparam logic [19:0] WIN_LAST_20  = 20'h07fff;
    localparam int          SYS_CLK_KHZ  = 20000;
    localparam int          SLOT_CLK_KHZ = 8000;
    // slot clock: toggle every half period, rounded down to whole cycles
    localparam int          CLK_HALF_CYC =
        (SYS_CLK_KHZ / (2 * SLOT_CLK_KHZ)) < 1 ? 1 :
        SYS_CLK_KHZ / (2 * SLOT_CLK_KHZ);
    localparam logic [3:0]  CLK_HALF_CNT = 4'(CLK_HALF_CYC);
    localparam logic [3:0]  STROBE_CYC   = 4'h2;

    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b000,
        BUS_ADDR  = 3'b001,
        BUS_STRB  = 3'b010,
        BUS_WAIT  = 3'b011,
        BUS_DONE  = 3'b100
    } bus_state_type;
endpackage
`default_nettype wire

//--- include/exp_chan_if.sv
// Purpose: slot-side wires of the expansion channel
// Assumes: data and ready resolved from enables here
// Notes:   ready and dma request are pulled up when nobody drives
`default_nettype none
interface exp_chan_if;
    import exp_chan_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic              ale;
    logic              slot_window_select_n;
    logic              slot_read_strobe_n;
    logic              slot_write_low_byte_n;
    logic              slot_write_high_byte;
    logic              transceiver_enable_n;
    logic              transfer_direction;
    logic              slot_reset_n;
    logic              slot_clk;
    logic [DATA_W-1:0] host_data_o;
    logic              host_data_oe;
    logic [DATA_W-1:0] card_data_o;
    logic              card_data_oe;
    logic              card_ready_oe;
    logic              card_dma_oe;
    logic [IRQ_N-1:0]  slot_irq_lines;
    wire  [DATA_W-1:0] data;
    wire               slot_ready_return;
    wire               slot_dma_request_n;

    assign data = host_data_oe ? host_data_o :
                  card_data_oe ? card_data_o : {DATA_W{1'b1}};
    assign slot_ready_return  = ~card_ready_oe;
    assign slot_dma_request_n = ~card_dma_oe;

    modport host (
        output addr, ale, slot_window_select_n, slot_read_strobe_n,
               slot_write_low_byte_n, slot_write_high_byte,
               transceiver_enable_n, transfer_direction, slot_reset_n,
               slot_clk, host_data_o, host_data_oe,
        input  data, slot_ready_return, slot_dma_request_n, slot_irq_lines
    );
    modport card (
        input  addr, ale, slot_window_select_n, slot_read_strobe_n,
               slot_write_low_byte_n, slot_write_high_byte,
               transceiver_enable_n, transfer_direction, slot_reset_n,
               slot_clk, data,
        output card_data_o, card_data_oe, card_ready_oe, card_dma_oe,
               slot_irq_lines
    );
endinterface
`default_nettype wire

//--- logic/pin_sync.sv
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs asynchronous to sys_clk_in
// Notes:   reset value is a parameter so idle-high pins start high
`default_nettype none
module pin_sync #(
    parameter int              WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             rstn_in,
    input  wire logic             clk_en_in,
    // pins
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            meta_q   <= INIT;
            sync_out <= INIT;
        end
        else if (clk_en_in)
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

//--- logic/exp_host_end.sv
// Purpose: host end of the expansion channel, drives slot bus cycles
// Assumes: one I/O request at a time from the user side
// Notes:   memory requests never reach the slots
`default_nettype none
module exp_host_end
    import exp_chan_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              rstn_in,
    input  wire logic              clk_en_in,
    // request from the processor side
    input  wire logic              req_valid_in,
    input  wire logic              req_is_io_in,
    input  wire logic              req_write_in,
    input  wire logic [19:0]       req_addr_in,
    input  wire logic [1:0]        req_byte_en_in,
    input  wire logic [DATA_W-1:0] req_wdata_in,
    output logic                   req_ready_out,
    output logic                   rsp_valid_out,
    output logic [DATA_W-1:0]      rsp_rdata_out,
    // events toward the processor side
    output logic [IRQ_N-1:0]       irq_pulse_out,
    output logic                   dma_request_out,
    // slot channel
    exp_chan_if.host               bus
);
    bus_state_type     state_q;
    logic [3:0]        cnt_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] rdata_q;
    logic              write_q;
    logic              sel_q;
    logic [1:0]        be_q;
    logic              rsp_q;
    logic              in_window;
    logic              rdy_s;
    logic              dma_s_n;
    logic [IRQ_N-1:0]  irq_s;
    logic [IRQ_N-1:0]  irq_prev_q;
    logic [3:0]        clk_cnt_q;
    logic              slot_clk_q;

    // ------------------------------------------------------------
    // pin inputs
    // ------------------------------------------------------------
    pin_sync #(.WIDTH(IRQ_N + 2), .INIT({{IRQ_N{1'b0}}, 2'b11})) u_sync (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .clk_en_in  (clk_en_in),
        .async_in   ({bus.slot_irq_lines, bus.slot_ready_return,
                      bus.slot_dma_request_n}),
        .sync_out   ({irq_s, rdy_s, dma_s_n})
    );

    // ------------------------------------------------------------
    // window decode
    // ------------------------------------------------------------
    // window decode
    // memory cycles never select the slots
    assign in_window = req_is_io_in && req_addr_in >= WIN_BASE_20
                       && req_addr_in <= WIN_LAST_20;

    assign req_ready_out = (state_q == BUS_IDLE);
    assign rsp_valid_out = rsp_q;
    assign rsp_rdata_out = rdata_q;

    // ------------------------------------------------------------
    // bus cycle sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_q <= BUS_IDLE;
            cnt_q   <= 4'h0;
            rsp_q   <= 1'b0;
        end
        else if (clk_en_in)
        begin
            rsp_q <= 1'b0;
            case (state_q)
                BUS_IDLE:
                begin
                    // non-window requests complete at once, off the slots
                    if (req_valid_in && in_window)
                        state_q <= BUS_ADDR;
                    else if (req_valid_in)
                        rsp_q <= 1'b1;
                end
                BUS_ADDR:
                begin
                    state_q <= BUS_STRB;
                    cnt_q   <= STROBE_CYC;
                end
                BUS_STRB:
                begin
                    if (cnt_q > 4'h1)
                        cnt_q <= cnt_q - 4'h1;
                    else
                        state_q <= BUS_WAIT;
                end
                BUS_WAIT:
                begin
                    if (rdy_s)
                        state_q <= BUS_DONE;
                end
                BUS_DONE:
                begin
                    state_q <= BUS_IDLE;
                    rsp_q   <= 1'b1;
                end
                default:
                    state_q <= BUS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // address, data and select latches
    // ------------------------------------------------------------
    // latch address
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            addr_q  <= '0;
            wdata_q <= '0;
            write_q <= 1'b0;
            be_q    <= 2'b00;
            sel_q   <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (state_q == BUS_IDLE && req_valid_in)
            begin
                addr_q  <= req_addr_in[ADDR_W-1:0];
                wdata_q <= req_wdata_in;
                write_q <= req_write_in;
                be_q    <= req_byte_en_in;
                sel_q   <= in_window;
            end
            else if (state_q == BUS_DONE)
                sel_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            rdata_q <= '0;
        else if (clk_en_in && state_q == BUS_WAIT && rdy_s && !write_q)
            rdata_q <= bus.data;
    end

    // ------------------------------------------------------------
    // slot control outputs
    // ------------------------------------------------------------
    logic active;
    assign active = (state_q == BUS_STRB) || (state_q == BUS_WAIT);

    assign bus.addr                  = addr_q;
    assign bus.ale                   = (state_q == BUS_ADDR);
    assign bus.slot_window_select_n  = ~sel_q;
    assign bus.slot_read_strobe_n    = ~(active && !write_q);
    assign bus.slot_write_low_byte_n = ~(active && write_q && be_q[0]);
    assign bus.slot_write_high_byte  = active && write_q && be_q[1];
    assign bus.transceiver_enable_n  = ~(active || state_q == BUS_DONE);
    assign bus.transfer_direction    = write_q;
    assign bus.host_data_o           = wdata_q;
    assign bus.host_data_oe          = write_q && state_q != BUS_IDLE;
    assign bus.slot_reset_n          = rstn_in;
    // ready, dma request and the interrupt lines come back from slots

    // ------------------------------------------------------------
    // slot clock
    // ------------------------------------------------------------
    // divided slot clock
    // limitation: 20 MHz cannot give exactly 8 MHz; gives 10 MHz, the nearest above
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            clk_cnt_q  <= 4'h0;
            slot_clk_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (clk_cnt_q >= CLK_HALF_CNT - 4'h1)
            begin
                clk_cnt_q  <= 4'h0;
                slot_clk_q <= ~slot_clk_q;
            end
            else
                clk_cnt_q <= clk_cnt_q + 4'h1;
        end
    end
    assign bus.slot_clk = slot_clk_q;

    // ------------------------------------------------------------
    // interrupts and dma request
    // ------------------------------------------------------------
    // rising-edge detect
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            irq_prev_q    <= '0;
            irq_pulse_out <= '0;
        end
        else if (clk_en_in)
        begin
            irq_prev_q    <= irq_s;
            irq_pulse_out <= irq_s & ~irq_prev_q;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            dma_request_out <= 1'b0;
        else if (clk_en_in)
            dma_request_out <= ~dma_s_n;
    end
endmodule
`default_nettype wire

//--- logic/exp_card_end.sv
// Purpose: option-card end of the expansion channel
// Assumes: card logic runs on sys_clk_in; only data and write strobe pins synchronised
// Notes:   one 16-bit register per card at a chosen offset
`default_nettype none
module exp_card_end
    import exp_chan_pkg::*;
#(
    parameter logic [ADDR_W-1:0] CARD_ADDR = 16'h4000
) (
    // clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              rstn_in,
    input  wire logic              clk_en_in,
    // user side
    input  wire logic              dev_busy_in,
    input  wire logic [IRQ_N-1:0]  dev_irq_in,
    input  wire logic              dev_dma_req_in,
    input  wire logic [DATA_W-1:0] dev_rdata_in,
    output logic [DATA_W-1:0]      dev_wdata_out,
    output logic                   dev_write_out,
    // slot channel
    exp_chan_if.card               bus
);
    logic [ADDR_W-1:0] addr_q;
    logic              wl_s_n;
    logic              wh_s;
    logic              wl_prev_n;
    logic              wh_prev;
    logic [DATA_W-1:0] data_s;
    logic              hit;
    logic              rd_hit;

    // ------------------------------------------------------------
    // pin inputs
    // ------------------------------------------------------------
    pin_sync #(.WIDTH(DATA_W + 2), .INIT({{DATA_W{1'b0}}, 2'b10})) u_sync (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .clk_en_in  (clk_en_in),
        .async_in   ({bus.data, bus.slot_write_low_byte_n,
                      bus.slot_write_high_byte}),
        .sync_out   ({data_s, wl_s_n, wh_s})
    );

    // address is held stable through the cycle, so a plain latch on ALE
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            addr_q <= '0;
        else if (clk_en_in && bus.ale)
            addr_q <= bus.addr;
    end

    assign hit    = !bus.slot_window_select_n && addr_q == CARD_ADDR;
    assign rd_hit = hit && !bus.slot_read_strobe_n;

    assign bus.card_data_o  = dev_rdata_in;
    assign bus.card_data_oe = rd_hit;
    assign bus.card_ready_oe = hit && dev_busy_in;
    assign bus.card_dma_oe   = dev_dma_req_in;
    assign bus.slot_irq_lines = dev_irq_in;

    // byte writes
    // taken on the leading edge: the select ends one cycle after the strobes, so a
    // trailing-edge capture would find the card already deselected
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            wl_prev_n     <= 1'b1;
            wh_prev       <= 1'b0;
            dev_wdata_out <= '0;
            dev_write_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            wl_prev_n     <= wl_s_n;
            wh_prev       <= wh_s;
            dev_write_out <= 1'b0;
            if (hit && !wl_s_n && wl_prev_n)
            begin
                dev_wdata_out[7:0] <= data_s[7:0];
                dev_write_out      <= 1'b1;
            end
            if (hit && wh_s && !wh_prev)
            begin
                dev_wdata_out[15:8] <= data_s[15:8];
                dev_write_out       <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/exp_chan_properties.sv
// Purpose: timing checks on the wires between host and card ends
// Assumes: one clock domain, clk_en held high
// Notes:   inputs are plain copies of the interface signals
`default_nettype none
module exp_chan_properties (
    // clock and reset
    input wire logic        sys_clk_in,
    input wire logic        rstn_in,
    // slot channel
    input wire logic [15:0] addr,
    input wire logic        ale,
    input wire logic        slot_window_select_n,
    input wire logic        slot_read_strobe_n,
    input wire logic        slot_write_low_byte_n,
    input wire logic        slot_write_high_byte,
    input wire logic        transceiver_enable_n,
    input wire logic        transfer_direction,
    input wire logic        slot_reset_n,
    input wire logic        slot_clk
);
    default clocking @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    wire logic wr_on;
    wire logic strobe_on;
    assign wr_on = !slot_write_low_byte_n || slot_write_high_byte;
    assign strobe_on = wr_on || !slot_read_strobe_n;

    a_strobe_in_window: assert property (
        strobe_on |-> !slot_window_select_n)
        else $error("strobe outside the selected window");
    a_low_write_dir: assert property (
        !slot_write_low_byte_n |-> transfer_direction && slot_read_strobe_n)
        else $error("low byte write with wrong direction");
    a_high_write_dir: assert property (
        slot_write_high_byte |-> transfer_direction && slot_read_strobe_n)
        else $error("high byte write with wrong direction");
    a_read_dir_low: assert property (
        !slot_read_strobe_n |-> !transfer_direction && !wr_on)
        else $error("read strobe while transmitting");
    a_xcvr_on_write: assert property (
        wr_on |-> !transceiver_enable_n)
        else $error("write strobe without transceiver enable");
    a_reset_passes: assert property (
        disable iff (1'b0) slot_reset_n == rstn_in)
        else $error("slot reset differs from system reset");
    a_slot_clk_runs: assert property (
        $past(rstn_in, 2) |-> slot_clk != $past(slot_clk))
        else $error("slot clock stopped");
    a_ale_one_cycle: assert property (
        $rose(ale) |=> !ale)
        else $error("address latch strobe longer than a cycle");
    a_addr_held: assert property (
        !slot_window_select_n && !ale && !$past(slot_window_select_n)
        |-> $stable(addr))
        else $error("slot address moved within a cycle");
    a_strobe_after_ale: assert property (
        $rose(ale) && !slot_window_select_n |-> ##[1:2] strobe_on)
        else $error("no strobe after address latch");
    a_select_bounded: assert property (
        $fell(slot_window_select_n) |-> ##[1:60] slot_window_select_n)
        else $error("slot cycle never ended");
endmodule
`default_nettype wire

//--- verification/io_expansion_channel_bench.sv
// Purpose: self-checking bench joining host and card ends
// Assumes: clk_en tied high on both ends
// Notes:   slot wires are sampled on falling edges
`default_nettype none
module io_expansion_channel_bench import exp_chan_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // stimulus table
    // ------------------------------------------------------------
    typedef struct packed {
        logic        io;
        logic        wr;
        logic [19:0] adr;
        logic [1:0]  be;
        logic [15:0] wd;
        logic        sel;
    } row_type;
    localparam logic [15:0] CARD   = 16'h4000;
    localparam logic [15:0] RD_VAL = 16'h3c5a;
    localparam row_type ROWS [10] = '{
        '{1'b1, 1'b1, 20'h04000, 2'h3, 16'ha5c3, 1'b1},
        '{1'b1, 1'b1, 20'h04000, 2'h1, 16'h00ff, 1'b1},
        '{1'b1, 1'b1, 20'h04000, 2'h2, 16'hff00, 1'b1},
        '{1'b1, 1'b0, 20'h04000, 2'h3, 16'h0000, 1'b1},
        '{1'b1, 1'b1, 20'h07fff, 2'h3, 16'h1234, 1'b1},
        '{1'b1, 1'b1, 20'h03fff, 2'h3, 16'h1234, 1'b0},
        '{1'b1, 1'b1, 20'h08000, 2'h3, 16'h1234, 1'b0},
        '{1'b0, 1'b1, 20'h04000, 2'h3, 16'h1234, 1'b0},
        '{1'b1, 1'b0, 20'h14000, 2'h3, 16'h0000, 1'b0},
        '{1'b0, 1'b0, 20'h04000, 2'h3, 16'h0000, 1'b0}
    };

    logic              sys_clk_in = 1'b0;
    logic              rstn_in = 1'b0;
    logic              clk_en_in = 1'b1;
    logic              req_valid_in = 1'b0;
    logic              req_is_io_in = 1'b0;
    logic              req_write_in = 1'b0;
    logic [19:0]       req_addr_in = '0;
    logic [1:0]        req_byte_en_in = '0;
    logic [DATA_W-1:0] req_wdata_in = '0;
    logic              req_ready_out, rsp_valid_out, dma_request_out;
    logic [DATA_W-1:0] rsp_rdata_out, dev_wdata_out;
    logic [IRQ_N-1:0]  irq_pulse_out;
    logic              dev_busy_in = 1'b0;
    logic [IRQ_N-1:0]  dev_irq_in = '0;
    logic              dev_dma_req_in = 1'b0;
    logic [DATA_W-1:0] dev_rdata_in = RD_VAL;
    logic              dev_write_out;
    logic              s_sel, s_wrl, s_wrh, s_rd, s_dw, s_nrdy;
    logic [15:0]       s_wd, rdat, irq_seen;
    int                err_count = 0, n_compared = 0, cycles = 0;
    int                lat, n0, irq_cnt;
    logic              hit;

    exp_chan_if chan ();
    exp_host_end exp_host_end_inst (.sys_clk_in, .rstn_in, .clk_en_in,
        .req_valid_in, .req_is_io_in, .req_write_in, .req_addr_in,
        .req_byte_en_in, .req_wdata_in, .req_ready_out, .rsp_valid_out,
        .rsp_rdata_out, .irq_pulse_out, .dma_request_out, .bus(chan));
    exp_card_end #(.CARD_ADDR(CARD)) exp_card_end_inst (.sys_clk_in,
        .rstn_in, .clk_en_in, .dev_busy_in, .dev_irq_in, .dev_dma_req_in,
        .dev_rdata_in, .dev_wdata_out, .dev_write_out, .bus(chan));
    exp_chan_properties exp_chan_properties_inst (.sys_clk_in, .rstn_in,
        .addr(chan.addr), .ale(chan.ale),
        .slot_window_select_n(chan.slot_window_select_n),
        .slot_read_strobe_n(chan.slot_read_strobe_n),
        .slot_write_low_byte_n(chan.slot_write_low_byte_n),
        .slot_write_high_byte(chan.slot_write_high_byte),
        .transceiver_enable_n(chan.transceiver_enable_n),
        .transfer_direction(chan.transfer_direction),
        .slot_reset_n(chan.slot_reset_n), .slot_clk(chan.slot_clk));

    // ------------------------------------------------------------
    // clock, watchdog and wire monitor
    // ------------------------------------------------------------
    initial
    begin
        forever #25 sys_clk_in = ~sys_clk_in;
    end

    // budget is about seventy times the expected run length
    always @(posedge sys_clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            end_of_test();
        end
    end

    always @(negedge sys_clk_in)
    begin
        if (chan.slot_window_select_n === 1'b0) s_sel = 1'b1;
        if (chan.slot_write_low_byte_n === 1'b0) s_wrl = 1'b1;
        if (chan.slot_write_high_byte === 1'b1) s_wrh = 1'b1;
        if (chan.slot_read_strobe_n === 1'b0) s_rd = 1'b1;
        if (chan.slot_ready_return === 1'b0) s_nrdy = 1'b1;
        if (dev_write_out === 1'b1)
        begin
            s_dw = 1'b1;
            s_wd = dev_wdata_out;
        end
        if (irq_pulse_out !== '0)
        begin
            irq_cnt++;
            irq_seen = 16'(irq_pulse_out);
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // entered just after a rising edge with the host idle
    task automatic do_op(input row_type r, output int l);
        l = 0;
        {s_sel, s_wrl, s_wrh, s_rd, s_dw, s_nrdy} = '0;
        req_is_io_in = r.io;
        req_write_in = r.wr;
        req_addr_in = r.adr;
        req_byte_en_in = r.be;
        req_wdata_in = r.wd;
        req_valid_in = 1'b1;
        @(posedge sys_clk_in);
        #1 req_valid_in = 1'b0;
        while (rsp_valid_out !== 1'b1 && l < 80)
        begin
            @(negedge sys_clk_in);
            l++;
        end
        rdat = rsp_rdata_out;
        check(l < 80, 1'b1);
        repeat (4) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge sys_clk_in);
        #1;
        check(chan.slot_window_select_n, 1'b1);
        check(chan.slot_reset_n, 1'b0);
        check(req_ready_out, 1'b1);
        rstn_in = 1'b1;
        foreach (ROWS[i])
        begin
            do_op(ROWS[i], lat);
            hit = ROWS[i].sel && ROWS[i].adr[15:0] == CARD;
            check(s_sel, ROWS[i].sel);
            check(s_wrl, ROWS[i].sel & ROWS[i].wr & ROWS[i].be[0]);
            check(s_wrh, ROWS[i].sel & ROWS[i].wr & ROWS[i].be[1]);
            check(s_rd, ROWS[i].sel & !ROWS[i].wr);
            if (ROWS[i].wr && ROWS[i].be == 2'h3)
                check(s_dw, hit);
            if (hit && ROWS[i].wr && ROWS[i].be == 2'h3)
                check(s_wd, ROWS[i].wd);
            if (hit && !ROWS[i].wr)
                check(rdat, RD_VAL);
            if (i == 3)
                n0 = lat;
            $display("row %0d done", i);
        end
        // card stalls the read, host must stretch it
        dev_busy_in = 1'b1;
        fork
            do_op(ROWS[3], lat);
            begin
                repeat (10) @(posedge sys_clk_in);
                #1 dev_busy_in = 1'b0;
            end
        join
        check(s_nrdy, 1'b1);
        check(lat > n0 + 3, 1'b1);
        check(rdat, RD_VAL);
        $display("stretched read done");
        for (int b = 0; b < IRQ_N; b++)
        begin
            irq_cnt = 0;
            dev_irq_in = IRQ_N'(1) << b;
            repeat (10) @(posedge sys_clk_in);
            #1 dev_irq_in = '0;
            repeat (10) @(posedge sys_clk_in);
            #1;
            check(16'(irq_cnt), 16'h0001);
            check(irq_seen, 16'h0001 << b);
        end
        $display("interrupt lines done");
        dev_dma_req_in = 1'b1;
        repeat (6) @(posedge sys_clk_in);
        #1;
        check(chan.slot_dma_request_n, 1'b0);
        check(dma_request_out, 1'b1);
        repeat (6) @(posedge sys_clk_in);
        #1 dev_dma_req_in = 1'b0;
        check(dma_request_out, 1'b1);
        repeat (6) @(posedge sys_clk_in);
        #1;
        check(dma_request_out, 1'b0);
        $display("dma request done");
        rstn_in = 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1;
        check(chan.slot_reset_n, 1'b0);
        check(chan.ale, 1'b0);
        rstn_in = 1'b1;
        do_op(ROWS[0], lat);
        check(s_dw, 1'b1);
        check(s_wd, ROWS[0].wd);
        $display("second reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
